// [include/mld_pkg.sv]
/*
 * Shared constants for the move/load instruction decoder: register map,
 * opcode patterns, field positions, reset values and the phase type.
 * Assumes a single 200 MHz clock domain and 16-bit program words.
 */
package mld_pkg;

  // ==========================================================================
  // clock
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // ==========================================================================
  // instruction cycle phases
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } mld_phase_e;

  // decoded operation kinds
  typedef enum logic [2:0] {
    OP_NONE,
    OP_POINTER_LOAD,
    OP_REGISTER_MOVE,
    OP_MEM_TO_MEM,
    OP_BANK_LOAD,
    OP_LITERAL_LOAD,
    OP_WORK_STORE,
    OP_SECOND_WORD
  } mld_op_e;

  // ==========================================================================
  // opcode patterns and field positions
  localparam logic [5:0] OPC_REGISTER_MOVE = 6'h14;   // 0101 00da
  localparam logic [6:0] OPC_WORK_STORE = 7'h37;      // 0110 111a
  localparam logic [7:0] OPC_BANK_LOAD = 8'h01;       // 0000 0001
  localparam logic [7:0] OPC_LITERAL_LOAD = 8'h0e;    // 0000 1110
  localparam logic [9:0] OPC_POINTER_LOAD = 10'h3b8;  // 1110 1110 00
  localparam logic [3:0] OPC_MEM_SRC = 4'hc;          // 1100
  localparam logic [3:0] OPC_SECOND_TAG = 4'hf;       // 1111
  localparam logic [7:0] OPC_PTR_LOW_TAG = 8'hf0;     // 1111 0000
  localparam int unsigned BIT_DEST = 9;
  localparam int unsigned BIT_ACCESS = 8;
  localparam int unsigned PTR_COUNT = 3;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_WORK = 5'h08;
  localparam logic [4:0] REG_BANK = 5'h0c;
  localparam logic [4:0] REG_PC = 5'h10;
  localparam logic [4:0] REG_PTR0 = 5'h14;
  localparam logic [4:0] REG_PTR1 = 5'h18;
  localparam logic [4:0] REG_PTR2 = 5'h1c;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STAT_NEG_BIT = 0;
  localparam int unsigned STAT_ZERO_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_PHASE_LSB = 4;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [11:0] RST_PTR = 12'h000;

endpackage : mld_pkg

// [rtl/mld_phase_seq.sv]
/*
 * Four-phase instruction cycle sequencer.
 * Assumes run_i comes from a register in the same clock domain.
 */
`timescale 1ns/1ps
module mld_phase_seq (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  // phase
  output mld_pkg::mld_phase_e phase_o
);
  import mld_pkg::*;

  mld_phase_e phase_q;

  // ==========================================================================
  // sequencing: a started cycle always completes, so run only gates decode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_q <= PH_DECODE;
    end else begin
      unique case (phase_q)
        PH_DECODE: if (run_i) phase_q <= PH_READ;
        PH_READ: phase_q <= PH_PROCESS;
        PH_PROCESS: phase_q <= PH_WRITE;
        PH_WRITE: phase_q <= PH_DECODE;
      endcase
    end
  end

  assign phase_o = phase_q;

endmodule : mld_phase_seq

// [rtl/mld_bank_addr.sv]
/*
 * Forms a 12-bit data address from an 8-bit file field, the access bit
 * and the bank-select register. Purely combinational.
 */
`timescale 1ns/1ps
module mld_bank_addr #(
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  // operand
  input wire logic [7:0] file_i,
  input wire logic access_i,
  input wire logic [7:0] bank_i,
  // address
  output logic [11:0] addr_o
);

  // ==========================================================================
  // access bank: low half in bank 0, upper half in the top bank
  always_comb begin
    if (!access_i) begin
      addr_o = (file_i < ACCESS_SPLIT) ? {4'h0, file_i} : {4'hf, file_i};
    end else begin
      addr_o = {bank_i[3:0], file_i};
    end
  end

endmodule : mld_bank_addr

// [rtl/mld_core.sv]
/*
 * Move/load instruction decoder and executor with an Avalon-MM register
 * slave. Assumes program words are valid on pm_data_i while the decode
 * phase is shown and data memory answers reads combinationally.
 */
// Notes on behaviour
// - pointer load writes high part, then low byte
// - register move copies file, sets negative, zero
// - destination bit clear to work, set to file
// - access bit zero selects access bank
// - access bit one uses bank select register
// - file field reaches any byte of bank
// - memory move uses two 12-bit addresses
// - memory move may source or target work
// - memory move reads first, writes final phase
// - bank load writes literal, flags unchanged
// - literal load writes work, flags unchanged
// - store copies work to file, one cycle
`timescale 1ns/1ps
module mld_core #(
  parameter int PC_W = 16,
  parameter logic [11:0] WORK_ADDR = 12'hfe8,
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // program memory
  output logic [PC_W-1:0] pm_addr_o,
  input wire logic [15:0] pm_data_i,
  // data memory
  output logic [11:0] dm_addr_o,
  output logic dm_rd_o,
  input wire logic [7:0] dm_rdata_i,
  output logic dm_wr_o,
  output logic [7:0] dm_wdata_o
);
  import mld_pkg::*;

  // ==========================================================================
  // state
  mld_phase_e phase;
  logic run_q;
  logic [15:0] ir_q;
  logic [15:0] first_q;
  logic pend_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] w_q;
  logic [7:0] bsr_q;
  logic n_q;
  logic z_q;
  logic [11:0] ptr_q [PTR_COUNT];
  logic [7:0] rd_q;
  logic [7:0] res_q;
  logic ack_q;
  logic [31:0] rdata_q;
  mld_op_e op;
  logic [11:0] bank_addr;
  logic [11:0] rd_addr;
  logic [11:0] wr_addr;
  logic rd_en;
  logic wr_en;
  logic wr_to_work;
  logic [7:0] rd_mux;
  logic idle;
  logic host_wr;

  mld_phase_seq u_seq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run_q),
    .phase_o(phase)
  );

  mld_bank_addr #(
    .ACCESS_SPLIT(ACCESS_SPLIT)
  ) u_bank (
    .file_i(ir_q[7:0]),
    .access_i(ir_q[BIT_ACCESS]),
    .bank_i(bsr_q),
    .addr_o(bank_addr)
  );

  // ==========================================================================
  // decode
  always_comb begin
    op = OP_NONE;
    if (pend_q && ir_q[15:12] == OPC_SECOND_TAG) begin
      op = OP_SECOND_WORD;
    end else if (ir_q[15:10] == OPC_REGISTER_MOVE) begin
      op = OP_REGISTER_MOVE;
    end else if (ir_q[15:9] == OPC_WORK_STORE) begin
      op = OP_WORK_STORE;
    end else if (ir_q[15:8] == OPC_BANK_LOAD) begin
      op = OP_BANK_LOAD;
    end else if (ir_q[15:8] == OPC_LITERAL_LOAD) begin
      op = OP_LITERAL_LOAD;
    end else if (ir_q[15:6] == OPC_POINTER_LOAD) begin
      op = OP_POINTER_LOAD;
    end else if (ir_q[15:12] == OPC_MEM_SRC) begin
      op = OP_MEM_TO_MEM;
    end
  end

  // ==========================================================================
  // data memory access; the work register is mapped into data space
  always_comb begin
    rd_addr = (op == OP_MEM_TO_MEM) ? ir_q[11:0] : bank_addr;
    wr_addr = bank_addr;
    rd_en = (op == OP_REGISTER_MOVE) || (op == OP_MEM_TO_MEM);
    wr_en = 1'b0;
    if (op == OP_WORK_STORE) begin
      wr_en = 1'b1;
    end else if (op == OP_REGISTER_MOVE && ir_q[BIT_DEST]) begin
      wr_en = 1'b1;
    end else if (op == OP_SECOND_WORD && first_q[15:12] == OPC_MEM_SRC) begin
      wr_en = 1'b1;
      wr_addr = ir_q[11:0];
    end
  end

  assign wr_to_work = (wr_addr == WORK_ADDR);
  assign rd_mux = (rd_addr == WORK_ADDR) ? w_q : dm_rdata_i;
  // the dummy read of the second word is suppressed by rd_en
  assign dm_rd_o = (phase == PH_READ) && rd_en && (rd_addr != WORK_ADDR);
  assign dm_wr_o = (phase == PH_WRITE) && wr_en && !wr_to_work;
  assign dm_addr_o = (phase == PH_WRITE) ? wr_addr : rd_addr;
  assign dm_wdata_o = res_q;
  assign pm_addr_o = pc_q;

  // ==========================================================================
  // instruction register and fetch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ir_q <= 16'h0000;
    end else if (phase == PH_DECODE && run_q) begin
      ir_q <= pm_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
      first_q <= 16'h0000;
    end else if (phase == PH_WRITE) begin
      pend_q <= (op == OP_POINTER_LOAD) || (op == OP_MEM_TO_MEM);
      first_q <= ir_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc_q <= '0;
    end else if (phase == PH_WRITE) begin
      pc_q <= pc_q + 1'b1;
    end else if (host_wr && avs_address_i == REG_PC) begin
      pc_q <= avs_writedata_i[PC_W-1:0];
    end
  end

  // ==========================================================================
  // read and process phases
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_q <= 8'h00;
    end else if (phase == PH_READ) begin
      rd_q <= rd_en ? rd_mux : ir_q[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_q <= 8'h00;
    end else if (phase == PH_PROCESS && op != OP_SECOND_WORD) begin
      // a memory move holds its source here until the next cycle
      res_q <= (op == OP_WORK_STORE) ? w_q : rd_q;
    end
  end

  // ==========================================================================
  // write phase: working register, bank select, flags, pointers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_q <= RST_WORK;
    end else if (phase == PH_WRITE) begin
      if (op == OP_LITERAL_LOAD) begin
        w_q <= res_q;
      end else if (op == OP_REGISTER_MOVE && !ir_q[BIT_DEST]) begin
        w_q <= res_q;
      end else if (wr_en && wr_to_work && op == OP_SECOND_WORD) begin
        w_q <= res_q;
      end
    end else if (host_wr && avs_address_i == REG_WORK) begin
      w_q <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bsr_q <= RST_BANK;
    end else if (phase == PH_WRITE && op == OP_BANK_LOAD) begin
      bsr_q <= res_q;
    end else if (host_wr && avs_address_i == REG_BANK) begin
      bsr_q <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (phase == PH_WRITE && op == OP_REGISTER_MOVE) begin
      n_q <= res_q[7];
      z_q <= (res_q == 8'h00);
    end
  end

  // selector 3 names no pointer and is dropped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PTR_COUNT; i++) begin
        ptr_q[i] <= RST_PTR;
      end
    end else if (phase == PH_WRITE) begin
      for (int i = 0; i < PTR_COUNT; i++) begin
        if (op == OP_POINTER_LOAD && ir_q[5:4] == 2'(i)) begin
          ptr_q[i] <= {ir_q[3:0], 8'h00};
        end else if (op == OP_SECOND_WORD && first_q[15:6] == OPC_POINTER_LOAD &&
                     first_q[5:4] == 2'(i) && ir_q[15:8] == OPC_PTR_LOW_TAG) begin
          ptr_q[i] <= {ptr_q[i][11:8], ir_q[7:0]};
        end
      end
    end
  end

  // ==========================================================================
  // avalon-mm slave: one wait state on every access
  assign idle = !run_q && phase == PH_DECODE;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_readdata_o = rdata_q;
  // core state other than the run bit only changes from the bus while stopped between cycles
  assign host_wr = avs_write_i && ack_q && idle;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
    end else if (avs_write_i && ack_q && avs_address_i == REG_CTRL) begin
      run_q <= avs_writedata_i[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= 32'h0000_0000;
      unique case (avs_address_i)
        REG_CTRL: rdata_q[CTRL_RUN_BIT] <= run_q;
        REG_STATUS: begin
          rdata_q[STAT_NEG_BIT] <= n_q;
          rdata_q[STAT_ZERO_BIT] <= z_q;
          rdata_q[STAT_BUSY_BIT] <= !idle;
          rdata_q[STAT_PHASE_LSB +: 2] <= phase;
        end
        REG_WORK: rdata_q[7:0] <= w_q;
        REG_BANK: rdata_q[7:0] <= bsr_q;
        REG_PC: rdata_q[PC_W-1:0] <= pc_q;
        REG_PTR0: rdata_q[11:0] <= ptr_q[0];
        REG_PTR1: rdata_q[11:0] <= ptr_q[1];
        REG_PTR2: rdata_q[11:0] <= ptr_q[2];
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_phase_order;
    phase == PH_READ |=> phase == PH_PROCESS ##1 phase == PH_WRITE ##1 phase == PH_DECODE;
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("phase order broken");

  property p_literal_load;
    phase == PH_WRITE && op == OP_LITERAL_LOAD |=> w_q == $past(ir_q[7:0]) && $stable(n_q);
  endproperty
  a_literal_load: assert property (p_literal_load)
    else $error("literal load wrong");

  property p_bank_load;
    phase == PH_WRITE && op == OP_BANK_LOAD |=> bsr_q == $past(ir_q[7:0]) && $stable(z_q);
  endproperty
  a_bank_load: assert property (p_bank_load)
    else $error("bank load wrong");

  property p_store;
    phase == PH_WRITE && op == OP_WORK_STORE && !wr_to_work |-> dm_wr_o && dm_wdata_o == w_q;
  endproperty
  a_store: assert property (p_store)
    else $error("store wrong");

  property p_move_flags;
    phase == PH_WRITE && op == OP_REGISTER_MOVE |=> z_q == ($past(res_q) == 8'h00) &&
      n_q == $past(res_q[7]);
  endproperty
  a_move_flags: assert property (p_move_flags)
    else $error("move flags wrong");

  property p_move_to_work;
    op == OP_REGISTER_MOVE && !ir_q[BIT_DEST] |-> !dm_wr_o;
  endproperty
  a_move_to_work: assert property (p_move_to_work)
    else $error("move to work wrote memory");

  property p_access_bank;
    op == OP_REGISTER_MOVE && !ir_q[BIT_ACCESS] |-> bank_addr[7:0] == ir_q[7:0] &&
      bank_addr[11:8] == ((ir_q[7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hf);
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access bank address wrong");

  property p_m2m_write;
    dm_wr_o && phase == PH_WRITE && op != OP_WORK_STORE && op != OP_REGISTER_MOVE |->
      op == OP_SECOND_WORD && $past(phase, 4) == PH_WRITE;
  endproperty
  a_m2m_write: assert property (p_m2m_write)
    else $error("memory move write misplaced");

  property p_second_no_read;
    op == OP_SECOND_WORD |-> !dm_rd_o;
  endproperty
  a_second_no_read: assert property (p_second_no_read)
    else $error("second word read memory");

  property p_ptr_high;
    phase == PH_WRITE && op == OP_POINTER_LOAD && ir_q[5:4] == 2'd0 |=>
      ptr_q[0][11:8] == $past(ir_q[3:0]);
  endproperty
  a_ptr_high: assert property (p_ptr_high)
    else $error("pointer high part wrong");

endmodule : mld_core

// [testbench/mld_mem_model.sv]
/*
 * Far-side model: program word memory and 4096-byte data memory.
 * Assumes the core reads both combinationally and writes on dm_wr at the rising edge.
 */
`timescale 1ns/1ps
module mld_mem_model (
  // clock
  input wire logic clk_i,
  // program memory
  input wire logic [15:0] pm_addr_i,
  output logic [15:0] pm_data_o,
  // data memory
  input wire logic [11:0] dm_addr_i,
  input wire logic dm_rd_i,
  output logic [7:0] dm_rdata_o,
  input wire logic dm_wr_i,
  input wire logic [7:0] dm_wdata_i
);
  // ==========================================================================
  // storage and access counters
  logic [15:0] prog_mem [0:255];
  logic [7:0] data_mem [0:4095];
  int rd_cnt [0:4095];
  int wr_cnt [0:4095];
  logic [7:0] junk_q;

  initial begin
    for (int i = 0; i < 4096; i++) begin
      data_mem[i] = 8'h00;
      rd_cnt[i] = 0;
      wr_cnt[i] = 0;
    end
    for (int i = 0; i < 256; i++) begin
      prog_mem[i] = 16'h0000;
    end
    junk_q = 8'h5a;
  end

  // ==========================================================================
  // access
  // only 256 words deep, enough for the short test programs
  assign pm_data_o = prog_mem[pm_addr_i[7:0]];
  // unselected data lines churn so a late sample cannot pass by luck
  assign dm_rdata_o = dm_rd_i ? data_mem[dm_addr_i] : junk_q;

  always @(posedge clk_i) begin
    junk_q <= junk_q + 8'h3b;
    if (dm_rd_i) begin
      rd_cnt[dm_addr_i] <= rd_cnt[dm_addr_i] + 1;
    end
    if (dm_wr_i) begin
      // counter and stack bytes never appear in the loaded programs
      // no interrupt setup exists here to be changed by a memory move
      data_mem[dm_addr_i] <= dm_wdata_i;
      wr_cnt[dm_addr_i] <= wr_cnt[dm_addr_i] + 1;
    end
  end
endmodule : mld_mem_model

// [testbench/tb_move_load_instruction_decode.sv]
/*
 * Self-checking bench: register bus tasks, one program run, final checks.
 * Assumes mld_core with default parameters and the mld_mem_model far side.
 */
`timescale 1ns/1ps
module tb_move_load_instruction_decode;
  import mld_pkg::*;
  // ==========================================================================
  // signals
  logic clk_i;
  logic rst_n_i;
  logic [4:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [15:0] pm_addr_o;
  logic [15:0] pm_data_i;
  logic [11:0] dm_addr_o;
  logic dm_rd_o;
  logic [7:0] dm_rdata_i;
  logic dm_wr_o;
  logic [7:0] dm_wdata_o;
  int error_cnt;
  int tests_run;
  logic [31:0] rd_q;
  logic [15:0] prog_words [0:19];

  mld_core mld_core_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o),
    .dm_rdata_i(dm_rdata_i), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o)
  );

  mld_mem_model mld_mem_model_i (
    .clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i), .dm_addr_i(dm_addr_o),
    .dm_rd_i(dm_rd_o), .dm_rdata_o(dm_rdata_i), .dm_wr_i(dm_wr_o), .dm_wdata_i(dm_wdata_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // tasks
  task automatic close_out;
    $display("mismatches %0d of %0d comparisons", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wait;
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (n == 40) begin
      error_cnt++;
      $display("unexpected at %0t: bus stall %h %h", $time, 32'h1, 32'h0);
      close_out();
    end
  endtask : bus_wait

  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    bus_wait();
    avs_write_i <= 1'b0;
  endtask : av_wr

  task automatic av_rd(input logic [4:0] a);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    bus_wait();
    rd_q = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask : av_rd

  // ==========================================================================
  // main sequence
  initial begin
    int n;
    rst_n_i = 1'b0;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    // bank load, literal, two stores, two moves, literal, three memory moves,
    // two pointer loads, bank load, store at the top of a bank
    prog_words = '{16'h0102, 16'h0e5a, 16'h6f10, 16'h6e90, 16'h5205, 16'h5120,
                   16'h0e77, 16'hc123, 16'hf456, 16'hcfe8, 16'hf457, 16'hc123,
                   16'hffe8, 16'hee23, 16'hf0ab, 16'hee0f, 16'hf0ff, 16'h010f,
                   16'h6fff, 16'h0000};
    #1;
    for (int i = 0; i < 20; i++) begin
      mld_mem_model_i.prog_mem[i] = prog_words[i];
    end
    mld_mem_model_i.data_mem[12'h220] = 8'h80;
    mld_mem_model_i.data_mem[12'h123] = 8'h33;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      av_rd(5'(a * 4));
      chk(rd_q, 32'h0);
    end
    av_rd(5'h01);
    chk(rd_q, 32'h0);
    av_wr(REG_WORK, 32'h12);
    av_rd(REG_WORK);
    chk(rd_q, 32'h12);
    av_wr(REG_PTR0, 32'h55);
    av_rd(REG_PTR0);
    chk(rd_q, 32'h0);
    av_wr(REG_CTRL, 32'h1);
    av_rd(REG_STATUS);
    chk(rd_q & 32'h4, 32'h4);
    for (n = 0; n < 400; n++) begin
      av_rd(REG_PC);
      if (rd_q >= 32'd19) break;
    end
    if (n == 400) begin
      error_cnt++;
      $display("unexpected at %0t: program stall %h %h", $time, rd_q, 32'd19);
      close_out();
    end
    // refused while running, bank stays at the program's value
    av_wr(REG_BANK, 32'h0a);
    av_wr(REG_CTRL, 32'h0);
    repeat (16) @(posedge clk_i);
    av_rd(REG_BANK);
    chk(rd_q, 32'h0f);
    av_rd(REG_WORK);
    chk(rd_q, 32'h33);
    av_rd(REG_STATUS);
    chk(rd_q, 32'h1);
    av_rd(REG_PTR2);
    chk(rd_q, 32'h3ab);
    av_rd(REG_PTR0);
    chk(rd_q, 32'hfff);
    av_rd(REG_PTR1);
    chk(rd_q, 32'h0);
    chk({24'h0, mld_mem_model_i.data_mem[12'h210]}, 32'h5a);
    chk({24'h0, mld_mem_model_i.data_mem[12'hf90]}, 32'h5a);
    chk(32'(mld_mem_model_i.wr_cnt[12'h005]), 32'h1);
    chk(32'(mld_mem_model_i.wr_cnt[12'h220]), 32'h0);
    chk({24'h0, mld_mem_model_i.data_mem[12'h456]}, 32'h33);
    chk({24'h0, mld_mem_model_i.data_mem[12'h457]}, 32'h77);
    chk(32'(mld_mem_model_i.rd_cnt[12'h123]), 32'h2);
    chk(32'(mld_mem_model_i.rd_cnt[12'h456]), 32'h0);
    chk(32'(mld_mem_model_i.wr_cnt[12'h456]), 32'h1);
    chk({24'h0, mld_mem_model_i.data_mem[12'hfff]}, 32'h33);
    close_out();
  end
endmodule : tb_move_load_instruction_decode
